//--- ovrs_supervisor.sv
// Purpose: output voltage reset supervisor with open-drain reset line and APB register file
// Assumes: comparator flags, enable, soft-start done and the resistor code come from the analog side
// Notes:   the resistor code is a static strap, so a plain two-stage sync per bit is enough
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "ovrs_regs.svh"
module ovrs_supervisor #(
	parameter int unsigned CNT_W     = 24,
	parameter int unsigned ADDR_W    = 12,
	parameter int unsigned PON_CYC_0 = `OVRS_MS_TO_CYC(`OVRS_T_PON_0_MS),
	parameter int unsigned PON_CYC_1 = `OVRS_MS_TO_CYC(`OVRS_T_PON_1_MS),
	parameter int unsigned PON_CYC_2 = `OVRS_MS_TO_CYC(`OVRS_T_PON_2_MS),
	parameter int unsigned PON_CYC_3 = `OVRS_MS_TO_CYC(`OVRS_T_PON_3_MS),
	parameter int unsigned RUN_CYC_1 = `OVRS_MS_TO_CYC(`OVRS_T_RUN_1_MS),
	parameter int unsigned RUN_CYC_2 = `OVRS_MS_TO_CYC(`OVRS_T_RUN_2_MS),
	parameter int unsigned RUN_CYC_3 = `OVRS_MS_TO_CYC(`OVRS_T_RUN_3_MS)
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                clk_en,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                regulator_enable,
	input  wire logic                soft_start_done,
	input  wire ovrs_pkg::ovrs_cmp_s feedback_sense,
	input  wire logic [3:0]          delay_select_pin,
	output ovrs_pkg::ovrs_lim_s      limits,
	input  wire logic                reset_out_n_i,
	output logic                     reset_out_n_o,
	output logic                     reset_out_n_oe,
	output logic                     irq
);
	import ovrs_pkg::*;

	localparam int unsigned RUN_CYC_0 = `OVRS_MS_TO_CYC(`OVRS_T_RUN_0_MS);
	localparam int unsigned BLANK_CYC = `OVRS_US_TO_CYC(`OVRS_T_BLANK_US);

	if (CNT_W > 32 || ADDR_W < 5 || ADDR_W > 32 || BLANK_CYC < 1 || RUN_CYC_0 < 1 ||
	    PON_CYC_0 < 1 || PON_CYC_1 < 1 || PON_CYC_2 < 1 || PON_CYC_3 < 1 ||
	    RUN_CYC_1 < 1 || RUN_CYC_2 < 1 || RUN_CYC_3 < 1 ||
	    PON_CYC_0 >= 2**CNT_W || PON_CYC_1 >= 2**CNT_W || PON_CYC_2 >= 2**CNT_W ||
	    PON_CYC_3 >= 2**CNT_W || RUN_CYC_1 >= 2**CNT_W || RUN_CYC_2 >= 2**CNT_W ||
	    RUN_CYC_3 >= 2**CNT_W || BLANK_CYC >= 2**CNT_W) begin : g_chk
		$error("supervisor parameters out of range");
	end

	typedef struct packed {
		ovrs_state_e st;
		logic        rel;
		ovrs_cfg_s   cfg;
		ovrs_lim_s   lim;
		ovrs_evt_t   status;
		ovrs_evt_t   mask;
		logic        force_low;
		logic        irq;
		logic [31:0] rdata;
		logic        out_prev;
		ovrs_cmp_s   cmp_s1;
		ovrs_cmp_s   cmp_s2;
		logic        en_s1;
		logic        en_s2;
		logic        ss_s1;
		logic        ss_s2;
		logic        line_s1;
		logic        line_s2;
		logic [3:0]  code_s1;
		logic [3:0]  code_s2;
	} ovrs_sup_s;

	localparam ovrs_sup_s SUP_RST = '{st: ST_OFF, default: '0};

	ovrs_sup_s        q;
	ovrs_sup_s        n;
	logic             bad;
	logic             bad_run;
	logic             blank_expired;
	logic             dly_expired;
	logic             dly_clear;
	logic             dly_run;
	logic [CNT_W-1:0] dly_limit;
	logic             setup;
	logic             access;
	logic             hit;
	logic [31:0]      rd_word;
	ovrs_evt_t        evt;
	ovrs_evt_t        clr;

	// resistor code table: delay group and undervoltage step
	function automatic ovrs_cfg_s decode_code(input logic [3:0] c);
		ovrs_cfg_s r;
		r.code = c;
		unique case (c)
			4'h0, 4'h1, 4'h2, 4'h3: begin
				r.dly_grp = 2'h0;
				r.uv_sel  = c[1:0];
			end
			4'h4, 4'h5, 4'h6, 4'h7: begin
				r.dly_grp = 2'h1;
				r.uv_sel  = c[1:0];
			end
			4'h8, 4'h9, 4'hA: begin
				r.dly_grp = 2'h2;
				r.uv_sel  = 2'(c - 4'h7);
			end
			4'hB, 4'hC: begin
				r.dly_grp = 2'h3;
				r.uv_sel  = 2'(c - 4'hB);
			end
			default: begin
				r.dly_grp = 2'h2;
				r.uv_sel  = 2'h0;
			end
		endcase
		return r;
	endfunction

	// share of the nominal feedback level, in millivolts
	function automatic logic [15:0] pct_mv(input logic [7:0] pct);
		return 16'((32'(`OVRS_NOM_MV) * 32'(pct)) / 32'(`OVRS_PCT_FULL));
	endfunction

	function automatic ovrs_lim_s limits_of(input ovrs_cfg_s c);
		ovrs_lim_s  l;
		logic [7:0] uv;
		unique case (c.uv_sel)
			2'h0: uv = `OVRS_UV_PCT_0;
			2'h1: uv = `OVRS_UV_PCT_1;
			2'h2: uv = `OVRS_UV_PCT_2;
			2'h3: uv = `OVRS_UV_PCT_3;
		endcase
		l.undervoltage_limit = pct_mv(8'(`OVRS_PCT_FULL - uv));
		l.undervoltage_clear = pct_mv(8'(`OVRS_PCT_FULL - uv + `OVRS_HYS_PCT));
		l.overvoltage_limit  = pct_mv(8'(`OVRS_PCT_FULL + `OVRS_OV_PCT));
		l.overvoltage_clear  = pct_mv(8'(`OVRS_PCT_FULL + `OVRS_OV_PCT - `OVRS_HYS_PCT));
		return l;
	endfunction

	function automatic logic [CNT_W-1:0] pon_cyc(input logic [1:0] g);
		unique case (g)
			2'h0: return CNT_W'(PON_CYC_0);
			2'h1: return CNT_W'(PON_CYC_1);
			2'h2: return CNT_W'(PON_CYC_2);
			2'h3: return CNT_W'(PON_CYC_3);
		endcase
	endfunction

	function automatic logic [CNT_W-1:0] run_cyc(input logic [1:0] g);
		unique case (g)
			2'h0: return CNT_W'(RUN_CYC_0);
			2'h1: return CNT_W'(RUN_CYC_1);
			2'h2: return CNT_W'(RUN_CYC_2);
			2'h3: return CNT_W'(RUN_CYC_3);
		endcase
	endfunction

	assign bad     = q.cmp_s2.uv_below | q.cmp_s2.ov_above;
	assign bad_run = bad && (q.st == ST_RUN);

	// blanking filter: counts only while out of window in normal run
	ovrs_timer #(
		.CNT_W (CNT_W)
	) u_blank (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (clk_en),
		.clear   (!bad_run),
		.run     (bad_run),
		.limit   (CNT_W'(BLANK_CYC)),
		.expired (blank_expired)
	);

	assign dly_run   = (q.st == ST_PON) || (q.st == ST_RECOV);
	assign dly_clear = (n.st != q.st);
	assign dly_limit = (q.st == ST_PON) ? pon_cyc(q.cfg.dly_grp) : run_cyc(q.cfg.dly_grp);

	ovrs_timer #(
		.CNT_W (CNT_W)
	) u_delay (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (clk_en),
		.clear   (dly_clear),
		.run     (dly_run),
		.limit   (dly_limit),
		.expired (dly_expired)
	);

	assign setup  = psel && !penable;
	assign access = psel && penable;
	assign hit    = (paddr == ADDR_W'(`OVRS_REG_STATUS)) || (paddr == ADDR_W'(`OVRS_REG_MASK)) ||
	                (paddr == ADDR_W'(`OVRS_REG_CTRL)) || (paddr == ADDR_W'(`OVRS_REG_STATE)) ||
	                (paddr == ADDR_W'(`OVRS_REG_CONFIG));

	always_comb begin
		rd_word = 32'h0000_0000;
		if (paddr == ADDR_W'(`OVRS_REG_STATUS)) begin
			rd_word = {27'h0, q.status};
		end else if (paddr == ADDR_W'(`OVRS_REG_MASK)) begin
			rd_word = {27'h0, q.mask};
		end else if (paddr == ADDR_W'(`OVRS_REG_CTRL)) begin
			rd_word = {31'h0, q.force_low};
		end else if (paddr == ADDR_W'(`OVRS_REG_STATE)) begin
			rd_word = {20'h0, q.line_s2, q.cmp_s2, q.rel, q.st};
		end else if (paddr == ADDR_W'(`OVRS_REG_CONFIG)) begin
			rd_word = {24'h0, q.cfg};
		end
	end

	always_comb begin
		n   = q;
		evt = '0;
		clr = '0;

		n.cmp_s1  = feedback_sense;
		n.cmp_s2  = q.cmp_s1;
		n.en_s1   = regulator_enable;
		n.en_s2   = q.en_s1;
		n.ss_s1   = soft_start_done;
		n.ss_s2   = q.ss_s1;
		n.line_s1 = reset_out_n_i;
		n.line_s2 = q.line_s1;
		n.code_s1 = delay_select_pin;
		n.code_s2 = q.code_s1;

		unique case (q.st)
			ST_OFF: begin
				if (q.en_s2) begin
					n.st  = ST_SOFT;
					n.cfg = decode_code(q.code_s2);
				end
			end
			ST_SOFT: begin
				if (q.ss_s2) begin
					n.st = ST_PON;
				end
			end
			ST_PON: begin
				if (dly_expired) begin
					n.st = bad ? ST_FAULT : ST_RUN;
					evt[`OVRS_EVT_UV] = q.cmp_s2.uv_below;
					evt[`OVRS_EVT_OV] = q.cmp_s2.ov_above;
				end
			end
			ST_RUN: begin
				if (blank_expired) begin
					n.st = ST_FAULT;
					evt[`OVRS_EVT_UV] = q.cmp_s2.uv_below;
					evt[`OVRS_EVT_OV] = q.cmp_s2.ov_above;
				end
			end
			ST_FAULT: begin
				if (q.cmp_s2.uv_above_hys && q.cmp_s2.ov_below_hys) begin
					n.st = ST_RECOV;
				end
			end
			ST_RECOV: begin
				if (bad) begin
					n.st = ST_FAULT;
					evt[`OVRS_EVT_UV] = q.cmp_s2.uv_below;
					evt[`OVRS_EVT_OV] = q.cmp_s2.ov_above;
				end else if (dly_expired) begin
					n.st = ST_RUN;
				end
			end
		endcase
		if (!q.en_s2) begin
			n.st = ST_OFF;
		end

		n.lim      = limits_of(n.cfg);
		n.out_prev = bad_run;
		n.rel      = (n.st == ST_RUN) && !q.force_low;
		evt[`OVRS_EVT_GLITCH]  = q.out_prev && !bad_run && (q.st == ST_RUN);
		evt[`OVRS_EVT_ASSERT]  = q.rel && !n.rel;
		evt[`OVRS_EVT_RELEASE] = !q.rel && n.rel;

		if (setup && !pwrite) begin
			n.rdata = rd_word;
		end
		if (access && hit && pwrite) begin
			if (paddr == ADDR_W'(`OVRS_REG_MASK)) begin
				n.mask = pwpack(pwdata);
			end
			if (paddr == ADDR_W'(`OVRS_REG_CTRL)) begin
				n.force_low = pwdata[`OVRS_CTRL_FORCE];
			end
		end
		// clear only the bits software was shown; a new event still wins
		if (access && !pwrite && (paddr == ADDR_W'(`OVRS_REG_STATUS))) begin
			clr = q.rdata[4:0];
		end
		n.status = (q.status & ~clr) | evt;
		n.irq    = |(n.status & n.mask);
	end

	function automatic ovrs_evt_t pwpack(input logic [31:0] w);
		return w[4:0];
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= SUP_RST;
		end else if (clk_en) begin
			q <= n;
		end
	end

	assign prdata         = q.rdata;
	assign pready         = 1'b1;
	assign pslverr        = access && !hit;
	assign limits         = q.lim;
	assign reset_out_n_o  = 1'b0;
	assign reset_out_n_oe = !q.rel;
	assign irq            = q.irq;

endmodule

//--- ovrs_regs.svh
// Purpose: offsets, field positions, limit percentages and timing figures of the output voltage reset supervisor
// Assumes: pclk at 100 MHz; APB slave with 32-bit data, one aligned word per register
// Notes:   times keep their printed unit; cycle counts derive from them and the clock period
// How it works
// - reset line released inside the voltage window, pulled low outside it
// - release after soft-start completes and then the power-on delay elapses
// - resistor code latched once at initialization, then held unchanged
// - feedback below undervoltage limit pulls reset low after blanking
// - undervoltage recovery needs limit plus hysteresis, then the in-run delay
// - feedback above overvoltage limit pulls reset low after blanking
// - overvoltage recovery needs limit minus hysteresis, then the in-run delay
// - overvoltage limit is fixed; only undervoltage limit and delays selectable
// - excursions shorter than blanking time leave the reset released
// - codes 0..3: 0.06 ms / 0.03 ms, limits -8, -14, -25, -40 percent
// - codes 4..7: 1.9 ms / 1.3 ms, limits -8, -14, -25, -40 percent
// - codes 8..10: 7.7/5.1 ms with -14,-25,-40; codes 11,12: 15.4/10.2 ms
// - open or highest code: 7.7 ms / 5.1 ms with -8 percent
// - percentages refer to the nominal 5 V feedback level
// - overvoltage limit at plus seven percent, one percent hysteresis
`ifndef OVRS_REGS_SVH
`define OVRS_REGS_SVH

`define OVRS_REG_STATUS      12'h000
`define OVRS_REG_MASK        12'h004
`define OVRS_REG_CTRL        12'h008
`define OVRS_REG_STATE       12'h00C
`define OVRS_REG_CONFIG      12'h010

`define OVRS_EVT_UV          0
`define OVRS_EVT_OV          1
`define OVRS_EVT_ASSERT      2
`define OVRS_EVT_RELEASE     3
`define OVRS_EVT_GLITCH      4
`define OVRS_CTRL_FORCE      0

`define OVRS_CODE_OPEN       4'hD

`define OVRS_NOM_MV          16'h1388
`define OVRS_PCT_FULL        8'h64
`define OVRS_UV_PCT_0        8'h08
`define OVRS_UV_PCT_1        8'h0E
`define OVRS_UV_PCT_2        8'h19
`define OVRS_UV_PCT_3        8'h28
`define OVRS_OV_PCT          8'h07
`define OVRS_HYS_PCT         8'h01

`define OVRS_CLK_PERIOD_NS   10.0
`define OVRS_T_PON_0_MS      0.06
`define OVRS_T_PON_1_MS      1.9
`define OVRS_T_PON_2_MS      7.7
`define OVRS_T_PON_3_MS      15.4
`define OVRS_T_RUN_0_MS      0.03
`define OVRS_T_RUN_1_MS      1.3
`define OVRS_T_RUN_2_MS      5.1
`define OVRS_T_RUN_3_MS      10.2
`define OVRS_T_BLANK_US      5.0
`define OVRS_MS_TO_CYC(t)    ($rtoi((t) * 1.0E6 / `OVRS_CLK_PERIOD_NS + 0.5))
`define OVRS_US_TO_CYC(t)    ($rtoi((t) * 1.0E3 / `OVRS_CLK_PERIOD_NS + 0.5))

`endif

//--- ovrs_pkg.sv
// Purpose: shared types of the output voltage reset supervisor
// Assumes: nothing beyond the register header
// Notes:   comparator flags arrive from the analog side as one group
package ovrs_pkg;

	typedef enum logic [5:0] {
		ST_OFF   = 6'h01,
		ST_SOFT  = 6'h02,
		ST_PON   = 6'h04,
		ST_RUN   = 6'h08,
		ST_FAULT = 6'h10,
		ST_RECOV = 6'h20
	} ovrs_state_e;

	typedef struct packed {
		logic uv_below;
		logic uv_above_hys;
		logic ov_above;
		logic ov_below_hys;
	} ovrs_cmp_s;

	typedef struct packed {
		logic [3:0] code;
		logic [1:0] dly_grp;
		logic [1:0] uv_sel;
	} ovrs_cfg_s;

	typedef struct packed {
		logic [15:0] undervoltage_limit;
		logic [15:0] undervoltage_clear;
		logic [15:0] overvoltage_limit;
		logic [15:0] overvoltage_clear;
	} ovrs_lim_s;

	typedef logic [4:0] ovrs_evt_t;

endpackage

//--- ovrs_timer.sv
// Purpose: up counter that reports when it has reached a limit
// Assumes: limit is at least one and stable while running
// Notes:   clear has priority over run; the count stops at the limit
`timescale 1ns/100ps
module ovrs_timer #(
	parameter int unsigned CNT_W = 24
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             ce,
	input  wire logic             clear,
	input  wire logic             run,
	input  wire logic [CNT_W-1:0] limit,
	output logic                  expired
);
	import ovrs_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} ovrs_tmr_s;

	ovrs_tmr_s q;
	ovrs_tmr_s n;

	if (CNT_W < 1 || CNT_W > 32) begin : g_chk
		$error("timer width out of range");
	end

	assign expired = (q.cnt == limit);

	always_comb begin
		n = q;
		if (clear) begin
			n.cnt = '0;
		end else if (run && !expired) begin
			n.cnt = q.cnt + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else if (ce) begin
			q <= n;
		end
	end

endmodule

//--- ovrs_mcu_model.sv
// Purpose: host reset input with its pull-up on the supervised reset line
// Assumes: the block is the only party that pulls the line low
// Notes:   counts how often the line is let go
`timescale 1ns/100ps
module ovrs_mcu_model (
	input  wire logic oe,
	output logic      line,
	output int        releases
);
	import ovrs_pkg::*;
	// the pull-up wins whenever the block stops sinking
	assign line = oe ? 1'b0 : 1'b1;
	initial releases = 0;
	always @(posedge line) releases++;
endmodule

//--- ovrs_supervisor_checker.sv
// Purpose: port assertions for the output voltage reset supervisor
// Assumes: clk_en held high
// Notes:   saturating counters stand in for long waits
`timescale 1ns/100ps
module ovrs_supervisor_checker #(
	parameter int unsigned PON_CYC_0 = 40
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                regulator_enable,
	input  wire logic                soft_start_done,
	input  wire ovrs_pkg::ovrs_cmp_s feedback_sense,
	input  wire ovrs_pkg::ovrs_lim_s limits,
	input  wire logic                reset_out_n_o,
	input  wire logic                reset_out_n_oe
);
	import ovrs_pkg::*;
	logic        bad;
	logic [9:0]  bad_cnt_q;
	logic [15:0] up_cnt_q;
	logic [3:0]  en_cnt_q;
	assign bad = feedback_sense.uv_below | feedback_sense.ov_above;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bad_cnt_q <= 10'h0;
			up_cnt_q  <= 16'h0;
			en_cnt_q  <= 4'h0;
		end else begin
			bad_cnt_q <= bad ? bad_cnt_q + {9'h0, ~&bad_cnt_q} : 10'h0;
			up_cnt_q  <= (regulator_enable & soft_start_done) ? up_cnt_q + {15'h0, ~&up_cnt_q} : 16'h0;
			en_cnt_q  <= regulator_enable ? en_cnt_q + {3'h0, ~&en_cnt_q} : 4'h0;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_settled;
		$past(presetn, 2);
	endsequence
	sequence s_off;
		(!regulator_enable)[*5];
	endsequence
	AST_OPEN_DRAIN: assert property (reset_out_n_o == 1'b0)
		else $error("reset line driven high");
	AST_OFF_LOW: assert property (s_off |-> reset_out_n_oe)
		else $error("reset released while disabled");
	AST_RELEASE_WIN: assert property ($fell(reset_out_n_oe) |-> !$past(bad, 3) && !$past(bad, 4))
		else $error("released outside the window");
	AST_PON_DELAY: assert property ($fell(reset_out_n_oe) |-> up_cnt_q >= PON_CYC_0)
		else $error("released before power-on delay");
	AST_BLANK: assert property ($rose(reset_out_n_oe) |-> bad_cnt_q >= 10'h1EA || !$past(regulator_enable, 2))
		else $error("short excursion asserted reset");
	AST_FAULT: assert property (bad_cnt_q == 10'h1FE |-> ##[0:4] reset_out_n_oe)
		else $error("lasting fault left reset released");
	AST_OV_FIXED: assert property (s_settled |-> limits.overvoltage_limit == 16'h14E6 && limits.overvoltage_clear == 16'h14B4)
		else $error("overvoltage limit not fixed");
	AST_UV_TABLE: assert property (s_settled |-> limits.undervoltage_limit inside {16'h11F8, 16'h10CC, 16'h0EA6, 16'h0BB8} && limits.undervoltage_clear == limits.undervoltage_limit + 16'h32)
		else $error("undervoltage limit off table");
	AST_CFG_HELD: assert property (en_cnt_q == 4'hF |-> $stable(limits.undervoltage_limit))
		else $error("configuration changed while enabled");
endmodule
bind ovrs_supervisor ovrs_supervisor_checker #(.PON_CYC_0(PON_CYC_0)) chk_inst (
	.pclk(pclk),
	.presetn(presetn),
	.regulator_enable(regulator_enable),
	.soft_start_done(soft_start_done),
	.feedback_sense(feedback_sense),
	.limits(limits),
	.reset_out_n_o(reset_out_n_o),
	.reset_out_n_oe(reset_out_n_oe)
);

//--- ovrs_supervisor_tb.sv
// Purpose: self-checking bench for the output voltage reset supervisor
// Assumes: shortened delay parameters, clk_en held high except during the frozen-write check
// Notes:   tables give undervoltage steps and delays
`timescale 1ns/100ps
`include "ovrs_regs.svh"
`define CHK(s, e, g) begin compares++; if ((g) !== (e)) begin err_count++; $display("ERROR %s exp %0h got %0h", s, e, g); end end
module ovrs_supervisor_tb;
	import ovrs_pkg::*;
	localparam int PON[4] = '{40, 50, 60, 70};
	localparam int RUN[4] = '{3000, 40, 510000, 1020000};
	localparam int PCT[4] = '{8, 14, 25, 40};
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, regulator_enable, soft_start_done;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, er, line, o, oe, irq, ce;
	ovrs_cmp_s   fb;
	ovrs_lim_s   limits;
	logic [3:0]  code;
	int          err_count, compares, releases, n;
	always #5 pclk = ~pclk;
	ovrs_supervisor #(.PON_CYC_0(40), .PON_CYC_1(50), .PON_CYC_2(60), .PON_CYC_3(70),
		.RUN_CYC_1(40)) ovrs_supervisor_inst (
		.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .regulator_enable(regulator_enable), .soft_start_done(soft_start_done),
		.feedback_sense(fb), .delay_select_pin(code), .limits(limits), .reset_out_n_i(line),
		.reset_out_n_o(o), .reset_out_n_oe(oe), .irq(irq));
	ovrs_mcu_model ovrs_mcu_model_inst (.oe(oe), .line(line), .releases(releases));
	task final_report;
		$display("compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task cyc(input int c);
		repeat (c) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		`CHK("pready", 1'b1, pready)
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wait_oe(input logic v);
		n = 0;
		while (oe !== v && n < 4000) begin
			@(posedge pclk);
			n++;
		end
	endtask
	task chk_rng(input string s, input int lo);
		`CHK(s, 1'b1, n >= lo && n <= lo + 6)
	endtask
	task set_fb(input int k);
		fb <= '{k == 1, k != 1, k == 2, k != 2};
	endtask
	function automatic int cfg(input int c);
		if (c < 8)
			return c;
		if (c < 11)
			return c + 1;
		if (c < 13)
			return c + 1;
		return 8;
	endfunction
	task automatic power_up(input int c);
		int g;
		g = cfg(c);
		regulator_enable <= 1'b0;
		soft_start_done <= 1'b0;
		code <= c[3:0];
		cyc(8);
		apb(1'b0, `OVRS_REG_STATUS, 32'h0);
		regulator_enable <= 1'b1;
		cyc(8);
		code <= 4'($urandom);
		cyc(4);
		`CHK("uv limit", 16'(5000 - 50 * PCT[g % 4]), limits.undervoltage_limit)
		apb(1'b0, `OVRS_REG_CONFIG, 32'h0);
		`CHK("config", {c[3:0], g[3:0]}, rd[7:0])
		soft_start_done <= 1'b1;
		wait_oe(1'b0);
		chk_rng("power-on delay", PON[g / 4]);
		`CHK("line", 1'b1, line)
	endtask
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, regulator_enable, soft_start_done} = 5'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		code = 4'h0;
		ce = 1'b1;
		fb = '{1'b0, 1'b1, 1'b0, 1'b1};
		err_count = 0;
		compares = 0;
		void'($urandom(34));
		cyc(6);
		presetn <= 1'b1;
		cyc(2);
		`CHK("ov limit", 16'h14E6, limits.overvoltage_limit)
		for (int a = 0; a < 12; a += 4) begin
			apb(1'b0, a[11:0], 32'h0);
			`CHK("reset value", 32'h0, rd)
		end
		apb(1'b0, 12'h020, 32'h0);
		`CHK("unmapped", 1'b1, er)
		for (int c = 0; c < 16; c++)
			power_up(c);
		power_up(5);
		set_fb(1);
		cyc(20 + $urandom % 300);
		set_fb(0);
		cyc(600);
		`CHK("glitch", 1'b0, oe)
		`CHK("masked irq", 1'b0, irq)
		apb(1'b1, `OVRS_REG_MASK, 32'h1F);
		cyc(2);
		`CHK("irq", 1'b1, irq)
		apb(1'b0, `OVRS_REG_STATUS, 32'h0);
		`CHK("status", 32'h18, rd)
		cyc(2);
		`CHK("irq clear", 1'b0, irq)
		for (int k = 1; k < 3; k++) begin
			set_fb(k);
			wait_oe(1'b1);
			chk_rng("blanking", 500);
			cyc(3);
			`CHK("fault irq", 1'b1, irq)
			apb(1'b0, `OVRS_REG_STATUS, 32'h0);
			`CHK("fault status", 32'(k | 4), rd)
			set_fb(0);
			cyc(20);
			set_fb(k);
			cyc(3);
			set_fb(0);
			wait_oe(1'b0);
			chk_rng("in-run delay", RUN[1]);
			apb(1'b0, `OVRS_REG_STATUS, 32'h0);
			`CHK("release", 32'h8, rd & 32'h8)
		end
		// a write while the clock enable is low must not land
		ce <= 1'b0;
		apb(1'b1, `OVRS_REG_CTRL, 32'h1);
		ce <= 1'b1;
		apb(1'b0, `OVRS_REG_CTRL, 32'h0);
		`CHK("frozen ctrl", 32'h0, rd)
		`CHK("frozen line", 1'b0, oe)
		`CHK("releases", 19, releases)
		regulator_enable <= 1'b0;
		cyc(6);
		`CHK("disabled", 1'b1, oe)
		final_report;
	end
	initial begin
		#200000;
		err_count++;
		final_report;
	end
endmodule
